//--- core/cmd_decode_consts.svh
// offsets, field positions, reset values and timing counts of the decoder
// assumes inclusion by bare name from the package and the top module
`ifndef CMD_DECODE_CONSTS_SVH
`define CMD_DECODE_CONSTS_SVH
`define OFS_CMD_TYPE_FLAGS 8'h14
`define OFS_CMD_REF_CHANNEL 8'h15
`define OFS_CTRL 8'h18
`define OFS_STATUS 8'h19
`define OFS_IRQ_STATUS 8'h1a
`define OFS_IRQ_MASK 8'h1b
`define OFS_DONE_FLAGS_LO 8'h1c
`define OFS_DONE_FLAGS_HI 8'h1d
`define CTRL_SPECIAL_ACCESS 0
`define CTRL_ENABLE 1
`define CTRL_RESTART_MODE 2
`define CTRL_THREE_REF 3
`define IRQ_DONE 0
`define IRQ_EOS 1
`define IRQ_EOL 2
`define IRQ_ERR 3
`define RST_BYTE 8'h00
`define RST_DONE_FLAGS 15'h0000
`define CONV_TIME_NS 640
`define CLK_PERIOD_NS 40
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LIST_DEPTH 8
`define LIST_IDX_W 3
`define CH_EXT_COUNT 6'd16
`endif

//--- core/cmd_decode_pkg.sv
// types shared by the command decoder and its list memory
// assumes the constants header sits beside it
package cmd_decode_pkg;
  `include "cmd_decode_consts.svh"
  typedef enum logic [1:0]
  {
    CMD_NORMAL = 2'h0,
    CMD_END_SEQ = 2'h1,
    CMD_END_LIST_GO = 2'h2,
    CMD_END_LIST_WAIT = 2'h3
  } cmd_type_t;
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h0,
    ST_LOAD = 3'h1,
    ST_CONV = 3'h3,
    ST_STORE = 3'h2,
    ST_WAIT_RESTART = 3'h6,
    ST_HALT = 3'h4
  } seq_state_t;
endpackage

//--- core/cmd_list_mem.sv
// list of command entries, one 16-bit command (type/flags byte over ref/channel byte) per entry
// assumes a single clock; read data are registered
`timescale 1ns/1ps
module cmd_list_mem
  import cmd_decode_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic wr_en_i,
  input wire logic [`LIST_IDX_W-1:0] wr_idx_i,
  input wire logic [15:0] wr_data_i,
  input wire logic [`LIST_IDX_W-1:0] rd_idx_i,
  output logic [15:0] rd_data_o
);
  typedef struct packed
  {
    logic [`LIST_DEPTH-1:0][15:0] mem;
    logic [15:0] rd;
  } mem_state_t;
  mem_state_t st_ff;
  mem_state_t nxt_st;
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.rd = st_ff.mem[rd_idx_i];
    if (wr_en_i)
    begin
      nxt_st.mem[wr_idx_i] = wr_data_i;
    end
  end
  // no reset: contents are software-defined
  always_ff @(posedge clk_sys_i)
  begin
    st_ff <= nxt_st;
  end
  assign rd_data_o = st_ff.rd;
endmodule

//--- core/cmd_decode.sv
// command decoder and list sequencer for the converter
// assumes synchronous reset, one clock, trigger and restart from pins
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module cmd_decode
  import cmd_decode_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic trigger_i,
  input wire logic restart_i,
  output logic [1:0] chip_option_bits_o,
  output logic [1:0] high_reference_choice_o,
  output logic low_reference_choice_o,
  output logic [5:0] input_channel_choice_o,
  output logic conv_busy_o,
  output logic [15:1] conversion_done_flags_o,
  output logic command_error_flag_o,
  output logic [`LIST_IDX_W-1:0] result_index_o,
  output logic irq_o
);
  typedef struct packed
  {
    logic [1:0] trig_sync;
    logic [1:0] rst_sync;
    logic [7:0] cmd_hi;
    logic [7:0] cmd_lo;
    logic [`LIST_IDX_W-1:0] edit_idx;
    logic [3:0] ctrl;
    logic [15:1] done_flags;
    logic cmd_err;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [7:0] rdata;
    seq_state_t state;
    logic [`LIST_IDX_W-1:0] idx;
    logic [`LIST_IDX_W-1:0] res_idx;
    logic [7:0] cnt;
    logic [15:0] run_cmd;
    logic restart_seen;
    logic [1:0] chip_option_bits;
    logic [1:0] vrh;
    logic vrl;
    logic [5:0] ch;
    logic irq;
    logic busy;
  } top_state_t;
  top_state_t st_ff;
  top_state_t nxt_st;
  logic [15:0] mem_rdata;
  logic mem_wr;
  logic [15:0] mem_wdata;
  logic reserved_hit;
  logic trig;
  logic rst_ev;
  cmd_type_t run_type;
  // conversion length rounded up to whole clocks
  localparam logic [7:0] CONV_CNT = 8'(`CONV_CYCLES);
  localparam logic [5:0] EXT_CNT = `CH_EXT_COUNT;
  // next index, so the entry is read out by the load cycle
  cmd_list_mem cmd_list_mem_inst
  (
    .clk_sys_i(clk_sys_i),
    .wr_en_i(mem_wr),
    .wr_idx_i(st_ff.edit_idx),
    .wr_data_i(mem_wdata),
    .rd_idx_i(nxt_st.idx),
    .rd_data_o(mem_rdata)
  );
  // level trigger: a pin held high starts sequence after sequence
  assign trig = st_ff.trig_sync[1];
  assign rst_ev = st_ff.rst_sync[1];
  assign run_type = cmd_type_t'(st_ff.run_cmd[15:14]);
  // reserved check on the entry as it leaves the list, before it converts
  always_comb
  begin
    reserved_hit = 1'b0;
    if (st_ff.ctrl[`CTRL_THREE_REF] && mem_rdata[7:6] == 2'h3)
    begin
      reserved_hit = 1'b1;
    end
    // codes 3-7 only: internal sources 8-15 never count as reserved
    if (mem_rdata[5:0] >= 6'h03 && mem_rdata[5:0] <= 6'h07)
    begin
      reserved_hit = 1'b1;
    end
    if (mem_rdata[5])
    begin
      reserved_hit = 1'b1;
    end
    // pins above the implemented count; none while all sixteen exist
    if (mem_rdata[5:4] == 2'h1 && {2'h0, mem_rdata[3:0]} >= EXT_CNT)
    begin
      reserved_hit = 1'b1;
    end
  end
  // with special access set, a write to either byte updates the entry chosen by edit index
  assign mem_wr = wr_i && st_ff.ctrl[`CTRL_SPECIAL_ACCESS]
    && (addr_i == `OFS_CMD_TYPE_FLAGS || addr_i == `OFS_CMD_REF_CHANNEL);
  // shadows hold the last bytes written with special access set, not the entry under edit
  assign mem_wdata = (addr_i == `OFS_CMD_TYPE_FLAGS)
    ? {wdata_i, st_ff.cmd_lo} : {st_ff.cmd_hi, wdata_i};
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.trig_sync = {st_ff.trig_sync[0], trigger_i};
    nxt_st.rst_sync = {st_ff.rst_sync[0], restart_i};
    nxt_st.rdata = 8'h00;
    if (mem_wr)
    begin
      if (addr_i == `OFS_CMD_TYPE_FLAGS)
      begin
        nxt_st.cmd_hi = wdata_i;
      end
      else
      begin
        nxt_st.cmd_lo = wdata_i;
      end
    end
    // software clears come first; sequencer sets below win a tie
    if (wr_i)
    begin
      unique case (addr_i)
        `OFS_CTRL:
        begin
          nxt_st.ctrl = wdata_i[3:0];
          nxt_st.edit_idx = wdata_i[4+:`LIST_IDX_W];
        end
        `OFS_IRQ_STATUS: nxt_st.irq_stat = st_ff.irq_stat & ~wdata_i[3:0];
        `OFS_IRQ_MASK: nxt_st.irq_mask = wdata_i[3:0];
        `OFS_DONE_FLAGS_LO:
          nxt_st.done_flags[7:1] = st_ff.done_flags[7:1] & ~wdata_i[7:1];
        `OFS_DONE_FLAGS_HI:
          nxt_st.done_flags[15:8] = st_ff.done_flags[15:8] & ~wdata_i;
        `OFS_STATUS: nxt_st.cmd_err = st_ff.cmd_err & ~wdata_i[0];
        default: nxt_st.rdata = 8'h00;
      endcase
    end
    if (rd_i)
    begin
      unique case (addr_i)
        `OFS_CMD_TYPE_FLAGS: nxt_st.rdata = st_ff.cmd_hi;
        `OFS_CMD_REF_CHANNEL: nxt_st.rdata = st_ff.cmd_lo;
        `OFS_CTRL: nxt_st.rdata = {1'b0, st_ff.edit_idx, st_ff.ctrl};
        `OFS_STATUS: nxt_st.rdata = {st_ff.res_idx, st_ff.state,
          st_ff.restart_seen, st_ff.cmd_err};
        `OFS_IRQ_STATUS: nxt_st.rdata = {4'h0, st_ff.irq_stat};
        `OFS_IRQ_MASK: nxt_st.rdata = {4'h0, st_ff.irq_mask};
        `OFS_DONE_FLAGS_LO: nxt_st.rdata = {st_ff.done_flags[7:1], 1'b0};
        `OFS_DONE_FLAGS_HI: nxt_st.rdata = st_ff.done_flags[15:8];
        default: nxt_st.rdata = 8'h00;
      endcase
    end
    unique case (st_ff.state)
      ST_IDLE:
      begin
        if (st_ff.ctrl[`CTRL_ENABLE] && !st_ff.cmd_err && trig)
        begin
          nxt_st.state = ST_LOAD;
        end
      end
      ST_LOAD:
      begin
        // entry was read at the index registered on entry to this state
        // a bad entry halts here and never reaches the converter
        if (reserved_hit)
        begin
          nxt_st.cmd_err = 1'b1;
          nxt_st.irq_stat[`IRQ_ERR] = 1'b1;
          nxt_st.state = ST_HALT;
        end
        else
        begin
          nxt_st.run_cmd = mem_rdata;
          nxt_st.cnt = CONV_CNT;
          nxt_st.state = ST_CONV;
        end
      end
      ST_CONV:
      begin
        // outputs change once per entry, on the edge ending the first conversion cycle
        if (st_ff.cnt == CONV_CNT)
        begin
          nxt_st.chip_option_bits = st_ff.run_cmd[13:12];
          nxt_st.vrh = st_ff.ctrl[`CTRL_THREE_REF]
            ? st_ff.run_cmd[7:6] : {1'b0, st_ff.run_cmd[7]};
          nxt_st.vrl = st_ff.ctrl[`CTRL_THREE_REF]
            ? 1'b0 : st_ff.run_cmd[6];
          nxt_st.ch = st_ff.run_cmd[5:0];
          nxt_st.cnt = st_ff.cnt - 8'h01;
        end
        else if (st_ff.cnt == 8'h00)
        begin
          nxt_st.state = ST_STORE;
        end
        else
        begin
          nxt_st.cnt = st_ff.cnt - 8'h01;
        end
      end
      ST_STORE:
      begin
        // flag only after the result is stored
        nxt_st.res_idx = st_ff.idx;
        if (st_ff.run_cmd[11:8] != 4'h0)
        begin
          nxt_st.done_flags[st_ff.run_cmd[11:8]] = 1'b1;
          nxt_st.irq_stat[`IRQ_DONE] = 1'b1;
        end
        nxt_st.idx = st_ff.idx + `LIST_IDX_W'(1);
        unique case (run_type)
          CMD_NORMAL: nxt_st.state = ST_LOAD;
          CMD_END_SEQ:
          begin
            nxt_st.irq_stat[`IRQ_EOS] = 1'b1;
            nxt_st.state = ST_IDLE;
          end
          CMD_END_LIST_GO:
          begin
            nxt_st.irq_stat[`IRQ_EOL] = 1'b1;
            nxt_st.idx = '0;
            nxt_st.state = ST_LOAD;
          end
          CMD_END_LIST_WAIT:
          begin
            nxt_st.irq_stat[`IRQ_EOL] = 1'b1;
            nxt_st.idx = '0;
            nxt_st.restart_seen = 1'b0;
            nxt_st.state = st_ff.ctrl[`CTRL_RESTART_MODE]
              ? ST_WAIT_RESTART : ST_IDLE;
          end
        endcase
      end
      ST_WAIT_RESTART:
      begin
        // a trigger is dropped here until a restart arrives
        if (rst_ev)
        begin
          nxt_st.restart_seen = 1'b1;
          nxt_st.state = ST_IDLE;
        end
      end
      ST_HALT: nxt_st.state = ST_HALT;
      default: nxt_st.state = ST_HALT;
    endcase
    // restart returns to entry 0 from idle only, not from halt
    if (rst_ev && st_ff.state == ST_IDLE)
    begin
      nxt_st.idx = '0;
    end
    // only a software clear of the error bit leaves halt
    if (st_ff.state == ST_HALT && !nxt_st.cmd_err)
    begin
      nxt_st.state = ST_IDLE;
    end
    // next-state values, so irq moves with its status bit
    nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);
    // busy as a flop keeps every output straight off a register
    nxt_st.busy = (nxt_st.state == ST_CONV);
  end
  // list memory keeps its contents across reset
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end
  assign rdata_o = st_ff.rdata;
  assign chip_option_bits_o = st_ff.chip_option_bits;
  assign high_reference_choice_o = st_ff.vrh;
  assign low_reference_choice_o = st_ff.vrl;
  assign input_channel_choice_o = st_ff.ch;
  assign conv_busy_o = st_ff.busy;
  assign conversion_done_flags_o = st_ff.done_flags;
  assign command_error_flag_o = st_ff.cmd_err;
  assign result_index_o = st_ff.res_idx;
  assign irq_o = st_ff.irq;
endmodule

//--- verification/cmd_decode_assertions.sv
// port checks for the command decoder
// assumes a bind from the bench top; one clock, sync reset
`timescale 1ns/1ps
`include "cmd_decode_consts.svh"
module cmd_decode_chk
(
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [7:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic [1:0] high_reference_choice_o,
  input wire logic [5:0] input_channel_choice_o,
  input wire logic conv_busy_o,
  input wire logic [15:1] conversion_done_flags_o,
  input wire logic command_error_flag_o
);
  typedef struct packed
  {
    logic [4:0] idle;
    logic [4:0] run;
  } chk_state_t;
  chk_state_t st_ff;
  chk_state_t nxt_st;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // idle saturates so a long gap never wraps to a small count
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.run = conv_busy_o ? st_ff.run + 5'h1 : 5'h0;
    if (conv_busy_o)
      nxt_st.idle = 5'h0;
    else if (st_ff.idle != 5'h1f)
      nxt_st.idle = st_ff.idle + 5'h1;
    if (reset_i)
      nxt_st = '0;
  end
  always_ff @(posedge clk_sys_i)
    st_ff <= nxt_st;
  AST_RDATA_QUIET:
    assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside answer cycle");
  AST_FLAG_ONEHOT:
    assert property ($onehot0(conversion_done_flags_o &
      ~$past(conversion_done_flags_o)))
    else $error("several done flags at once");
  AST_FLAG_AFTER_STORE:
    assert property (|(conversion_done_flags_o &
      ~$past(conversion_done_flags_o)) |-> st_ff.idle <= 5'd3)
    else $error("done flag without conversion");
  AST_ERR_HALTS:
    assert property (command_error_flag_o && $past(command_error_flag_o)
      |-> !conv_busy_o)
    else $error("conversion under error");
  AST_ERR_CLEAR:
    assert property ($fell(command_error_flag_o) |->
      ($past(wr_i) && $past(addr_i) == `OFS_STATUS) ||
      ($past(wr_i, 2) && $past(addr_i, 2) == `OFS_STATUS))
    else $error("error flag dropped alone");
  AST_CHANNEL_LEGAL:
    assert property (conv_busy_o && $past(conv_busy_o) |->
      !input_channel_choice_o[5] &&
      !(input_channel_choice_o inside {[6'h03:6'h07]}))
    else $error("reserved channel converted");
  AST_HIGH_REF_LEGAL:
    assert property (conv_busy_o && $past(conv_busy_o) |->
      high_reference_choice_o != 2'h3)
    else $error("reserved reference converted");
  AST_CONV_LENGTH:
    assert property ($fell(conv_busy_o) |-> st_ff.run inside {[5'd16:5'd17]})
    else $error("conversion length off");
  cover property ($rose(conv_busy_o));
  cover property ($rose(command_error_flag_o));
  cover property ($rose(conversion_done_flags_o[15]));
endmodule

//--- verification/cmd_decode_tb_top.sv
// bench for the command decoder, one task per scenario
// assumes package, header and checker compiled first
`timescale 1ns/1ps
`include "cmd_decode_consts.svh"
module cmd_decode_tb_top;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic trigger_i = 1'b0;
  logic restart_i = 1'b0;
  logic [7:0] rdata_o;
  logic [1:0] chip_option_bits_o;
  logic [1:0] high_reference_choice_o;
  logic low_reference_choice_o;
  logic [5:0] input_channel_choice_o;
  logic conv_busy_o;
  logic [15:1] conversion_done_flags_o;
  logic command_error_flag_o;
  logic [`LIST_IDX_W-1:0] result_index_o;
  logic irq_o;
  int n_errors = 0;
  int checked = 0;
  int n_conv = 0;
  logic [10:0] seen [8];
  always #20 clk_sys_i = ~clk_sys_i;
  cmd_decode cmd_decode_inst
  (
    .clk_sys_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .trigger_i, .restart_i, .chip_option_bits_o, .high_reference_choice_o,
    .low_reference_choice_o, .input_channel_choice_o, .conv_busy_o,
    .conversion_done_flags_o, .command_error_flag_o, .result_index_o, .irq_o
  );
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, e);
  endtask
  task automatic rst();
    reset_i <= 1'b1;
    repeat (12) @(posedge clk_sys_i);
    reset_i <= 1'b0;
  endtask
  // entry index rides in the control byte, access bit kept on
  task automatic prog(input logic [2:0] i, input logic [15:0] c);
    wr(`OFS_CTRL, {1'b0, i, 4'h1});
    wr(`OFS_CMD_TYPE_FLAGS, c[15:8]);
    wr(`OFS_CMD_REF_CHANNEL, c[7:0]);
  endtask
  // one-cycle trigger is enough, the pin sync is two flops
  task automatic go(input logic [7:0] mode, input int cyc);
    logic p;
    p = 1'b0;
    n_conv = 0;
    wr(`OFS_CTRL, mode);
    trigger_i <= 1'b1;
    repeat (cyc)
    begin
      @(posedge clk_sys_i);
      trigger_i <= 1'b0;
      #1;
      if (conv_busy_o === 1'b1 && !p)
        n_conv++;
      if (conv_busy_o === 1'b1)
        seen[n_conv[2:0]] = {chip_option_bits_o, high_reference_choice_o,
          low_reference_choice_o, input_channel_choice_o};
      p = conv_busy_o;
    end
  endtask
  task automatic t_access();
    rst();
    wr(`OFS_CMD_TYPE_FLAGS, 8'hff);
    rd(`OFS_CMD_TYPE_FLAGS, 8'h00);
    wr(`OFS_CTRL, 8'h01);
    wr(`OFS_CMD_REF_CHANNEL, 8'h5a);
    rd(`OFS_CMD_REF_CHANNEL, 8'h5a);
    rd(8'h3f, 8'h00);
    $display("t_access done");
  endtask
  task automatic t_seq();
    rst();
    prog(3'h0, 16'h1190);
    prog(3'h1, 16'h6fc8);
    go(8'h03, 120);
    chk(n_conv, 2);
    chk(conversion_done_flags_o, 15'h4001);
    chk(seen[1], {2'h1, 2'h1, 1'b0, 6'h10});
    chk(seen[2], {2'h2, 2'h1, 1'b1, 6'h08});
    chk(command_error_flag_o, 1'b0);
    chk(result_index_o, 3'h1);
    rd(`OFS_IRQ_STATUS, 8'h03);
    rd(`OFS_DONE_FLAGS_HI, 8'h80);
    wr(`OFS_DONE_FLAGS_HI, 8'h80);
    rd(`OFS_DONE_FLAGS_HI, 8'h00);
    rd(`OFS_DONE_FLAGS_LO, 8'h02);
    $display("t_seq done");
  endtask
  task automatic t_loop();
    rst();
    prog(3'h0, 16'h0011);
    prog(3'h1, 16'h8212);
    go(8'h03, 200);
    chk(n_conv > 5, 1'b1);
    rst();
    prog(3'h0, 16'hc313);
    go(8'h03, 60);
    chk(n_conv, 1);
    go(8'h07, 60);
    chk(n_conv, 1);
    go(8'h07, 60);
    chk(n_conv, 0);
    restart_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    restart_i <= 1'b0;
    go(8'h07, 60);
    chk(n_conv, 1);
    $display("t_loop done");
  endtask
  task automatic t_err();
    rst();
    prog(3'h0, 16'h0081);
    prog(3'h1, 16'h40c1);
    wr(`OFS_IRQ_MASK, 8'h08);
    go(8'h0b, 120);
    chk(n_conv, 1);
    chk(seen[1], {2'h0, 2'h2, 1'b0, 6'h01});
    chk({command_error_flag_o, irq_o}, 2'h3);
    wr(`OFS_IRQ_MASK, 8'h00);
    go(8'h0b, 2);
    chk(irq_o, 1'b0);
    wr(`OFS_IRQ_MASK, 8'h08);
    wr(`OFS_IRQ_STATUS, 8'h08);
    wr(`OFS_STATUS, 8'h01);
    go(8'h08, 2);
    chk({command_error_flag_o, irq_o}, 2'h0);
    for (int k = 0; k < 2; k++)
    begin
      rst();
      prog(3'h0, k ? 16'h4021 : 16'h4005);
      go(8'h03, 60);
      chk({n_conv[0], command_error_flag_o}, 2'h1);
    end
    $display("t_err done");
  endtask
  task automatic conclude();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    t_access();
    t_seq();
    t_loop();
    t_err();
    conclude();
  end
  // tests need near 1000 cycles
  initial
  begin
    repeat (6000) @(posedge clk_sys_i);
    n_errors++;
    conclude();
  end
endmodule
bind cmd_decode cmd_decode_chk cmd_decode_chk_inst
(
  .clk_sys_i, .reset_i, .addr_i, .wr_i, .rd_i, .rdata_o,
  .high_reference_choice_o, .input_channel_choice_o, .conv_busy_o,
  .conversion_done_flags_o, .command_error_flag_o
);
